/* File: adc_feedback_model.sv */
// Behavioural filter and converter returning a set sample level
`timescale 1ns/100ps
module adc_feedback_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [9:0] level,
   input  wire logic       slow,
   output logic [9:0]      sample,
   output logic            valid,
   input  wire logic       ready
);
   // Held until taken; slow mode idles a cycle with junk data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         valid  <= 1'b0;
         sample <= 10'h000;
      end else if (!valid || ready) begin
         valid  <= !(slow && valid);
         sample <= (slow && valid) ? ~level : level;
      end
   end
endmodule

/* File: pwm_dither_chk.sv */
// Port-level checker for the dithering PWM controller
`timescale 1ns/100ps
module pwm_dither_chk
   import pwm_dither_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        pwm_output_pin,
   input wire logic        monitor_serial_port
);
   logic [9:0]  hi_q;
   logic [11:0] lo_q;
   // Run lengths; cleared in reset so a cut frame never looks short
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hi_q <= 10'h000;
         lo_q <= 12'h000;
      end else begin
         hi_q <= pwm_output_pin ? hi_q + 10'h001 : 10'h000;
         lo_q <= monitor_serial_port ? 12'h000 : lo_q + 12'h001;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_bresp_stands: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_busy_no_ready: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready during answer");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rdata_stands: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed");
   a_reset_idle: assert property (disable iff (1'b0)
      !aresetn |=> monitor_serial_port && !pwm_output_pin
      && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not idle");
   a_duty_not_full: assert property (
      hi_q < PWM_CYC) else $error("pwm high a whole period");
   a_bit_time: assert property (
      $rose(monitor_serial_port) && lo_q != 12'h000
      |-> lo_q % BIT_CYC == 0 && lo_q <= 9 * BIT_CYC)
      else $error("serial bit time wrong");
endmodule

bind pwm_dither_closed_loop pwm_dither_chk chk_u (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .pwm_output_pin, .monitor_serial_port);

/* File: pwm_dither_closed_loop.sv */
// Dithering PWM controller with ADC feedback, sample FIFO and monitor
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps

module sample_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("sample_fifo depth must be a power of two, at least 2");
      end
   end
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic [AW:0]      cnt_d;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];
   assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge aclk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end
   // Ready is a flop so the source sees back-pressure without a comb path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wp_q     <= '0;
         rp_q     <= '0;
         cnt_q    <= '0;
         in_ready <= 1'b1;
      end else begin
         wp_q     <= wp_q + AW'(push);
         rp_q     <= rp_q + AW'(pop);
         cnt_q    <= cnt_d;
         in_ready <= (cnt_d != (AW+1)'(DEPTH));
      end
   end
endmodule

module pwm_dither_closed_loop
   import pwm_dither_pkg::*;
#(
   parameter int unsigned FIFO_DEPTH = 8,
   parameter int unsigned CORR_CYCLES  = CORR_CYC,
   parameter int unsigned VALUE_CYCLES = VALUE_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [9:0]  feedback_analog_input,
   input  wire logic        feedback_valid,
   output logic             feedback_ready,
   output logic             pwm_output_pin,
   output logic             monitor_serial_port
);
   initial begin
      // Pacing counters are 22 and 20 bits wide
      if (CORR_CYCLES < 1 || CORR_CYCLES > 32'h0040_0000
          || VALUE_CYCLES < 1 || VALUE_CYCLES > 32'h0010_0000) begin
         $error("pacing counts out of range");
      end
   end

   // Registers
   logic        loop_en_q;
   logic        mon_en_q;
   logic [11:0] target_q;
   logic [11:0] setting_q;
   logic [11:0] meas_q;
   logic        test_run_q;
   logic [7:0]  test_code_q;
   logic [4:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;

   // Write path: address and data taken in either order
   wire aw_hs   = s_axi_awvalid & s_axi_awready;
   wire w_hs    = s_axi_wvalid & s_axi_wready;
   wire wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   wire wr_ctrl = wr_go & (awaddr_q == CTRL_OFS);
   wire wr_tgt  = wr_go & (awaddr_q == TARGET_OFS);
   wire wr_hit  = (awaddr_q == CTRL_OFS) | (awaddr_q == TARGET_OFS);
   wire test_start = wr_ctrl & wstrb_q[0] & wdata_q[CTRL_TEST_BIT]
                     & ~test_run_q;
   wire [11:0] tgt_wr = {wstrb_q[1] ? wdata_q[11:8] : target_q[11:8],
                         wstrb_q[0] ? wdata_q[7:0]  : target_q[7:0]};
   // Targets above the top code are clamped rather than refused
   wire [11:0] tgt_clamped = (tgt_wr > SETTING_MAX) ? SETTING_MAX
                                                   : tgt_wr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awaddr_q      <= '0;
         wdata_q       <= '0;
         wstrb_q       <= '0;
      end else begin
         if (aw_hs) begin
            s_axi_awready <= 1'b0;
            awaddr_q      <= s_axi_awaddr;
         end
         if (w_hs) begin
            s_axi_wready <= 1'b0;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Read path, answered the cycle after the address is taken
   wire        ar_hs = s_axi_arvalid & s_axi_arready;
   wire        rd_hit;
   wire [31:0] rd_mux;
   assign rd_hit = (s_axi_araddr == CTRL_OFS) | (s_axi_araddr == TARGET_OFS)
                 | (s_axi_araddr == SETTING_OFS) | (s_axi_araddr == MEAS_OFS)
                 | (s_axi_araddr == STATUS_OFS);
   assign rd_mux =
      (s_axi_araddr == CTRL_OFS)    ? {29'h0, test_run_q, mon_en_q,
                                       loop_en_q} :
      (s_axi_araddr == TARGET_OFS)  ? {20'h0, target_q} :
      (s_axi_araddr == SETTING_OFS) ? {20'h0, setting_q} :
      (s_axi_araddr == MEAS_OFS)    ? {20'h0, meas_q} :
      (s_axi_araddr == STATUS_OFS)  ? {23'h0, test_run_q, test_code_q} :
                                      32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // PWM step pacing: 256 steps spread over each period
   localparam int unsigned ACC_W = $clog2(PWM_CYC) + 1;
   logic [ACC_W-1:0] acc_q;
   wire  [ACC_W-1:0] acc_sum = acc_q + ACC_W'(PWM_STEPS);
   wire              step_en = (acc_sum >= ACC_W'(PWM_CYC));
   logic [7:0]       pcnt_q;
   logic [3:0]       seq_idx_q;
   logic [7:0]       duty_compare_reg;
   wire              period_end = step_en & (pcnt_q == 8'hFF);

   // 16-entry duty sequence and its rewrite walker
   logic [7:0]  seq_mem [SEQ_LEN];
   logic [11:0] table_src_q;
   logic        rw_busy_q;
   logic [3:0]  rw_idx_q;
   wire  [3:0]  rw_rev = {rw_idx_q[0], rw_idx_q[1], rw_idx_q[2], rw_idx_q[3]};
   // Bit-reversed slot order spreads the extra counts evenly
   wire  [7:0]  rw_entry = table_src_q[11:4]
                + 8'((rw_rev < table_src_q[3:0]) ? 1 : 0);

   always_ff @(posedge aclk) begin
      if (rw_busy_q) begin
         seq_mem[rw_idx_q] <= rw_entry;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_q            <= '0;
         pcnt_q           <= '0;
         seq_idx_q        <= '0;
         duty_compare_reg <= '0;
         pwm_output_pin   <= 1'b0;
      end else begin
         acc_q <= step_en ? acc_sum - ACC_W'(PWM_CYC) : acc_sum;
         if (step_en) begin
            pcnt_q <= pcnt_q + 8'h01;
         end
         if (period_end) begin
            seq_idx_q        <= seq_idx_q + 4'h1;
            duty_compare_reg <= test_run_q ? test_code_q
                                           : seq_mem[seq_idx_q];
         end
         // Count 0xFF is always low, so 0xFF duty is 255/256
         pwm_output_pin <= (pcnt_q < duty_compare_reg);
      end
   end

   // Sample FIFO and drain
   logic [9:0] smp;
   logic       smp_valid;
   logic       mon_pend_q;
   wire        drain = smp_valid & ~mon_pend_q;

   sample_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_data   (feedback_analog_input),
      .in_valid  (feedback_valid),
      .in_ready  (feedback_ready),
      .out_data  (smp),
      .out_valid (smp_valid),
      .out_ready (~mon_pend_q)
   );

   logic [13:0] s16_q;
   logic [17:0] s256_q;
   logic [17:0] blk_sum_q;
   logic [3:0]  c16_q;
   logic [7:0]  c256_q;
   logic [21:0] corr_cnt_q;
   logic [19:0] val_cnt_q;
   logic        val_due_q;
   logic        mon_en_d1_q;
   logic [15:0] mon_val_q;
   logic [2:0]  mon_nch_q;
   logic [7:0]  mon_term_q;
   logic [3:0]  line_cnt_q;
   wire  [13:0] s16_done  = s16_q + 14'(smp);
   wire  [17:0] s256_done = s256_q + 18'(smp);
   wire         g16  = drain & (c16_q == 4'hF);
   wire         g256 = drain & (c256_q == 8'hFF);
   wire         corr_tick = (corr_cnt_q == 22'(CORR_CYCLES - 1));
   wire  [18:0] round_sum = {1'b0, blk_sum_q} + 19'(ROUND_HALF);
   wire  [11:0] meas_new  = round_sum[17:6];
   wire         mon_start = mon_en_q & ~mon_en_d1_q;
   wire         fmt_take;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s16_q <= '0; s256_q <= '0; blk_sum_q <= '0;
         c16_q <= '0; c256_q <= '0; corr_cnt_q <= '0; meas_q <= '0;
      end else begin
         if (drain) begin
            c16_q  <= c16_q + 4'h1;
            c256_q <= c256_q + 8'h01;
            s16_q  <= g16 ? '0 : s16_done;
            s256_q <= g256 ? '0 : s256_done;
         end
         if (g256) begin
            blk_sum_q <= s256_done;
         end
         corr_cnt_q <= corr_tick ? '0 : corr_cnt_q + 22'h1;
         if (corr_tick) begin
            meas_q <= meas_new;
         end
      end
   end

   // Setting update: open loop follows target, closed loop steps by one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         setting_q   <= SETTING_RST;
         loop_en_q   <= 1'b0;
         mon_en_q    <= 1'b0;
         target_q    <= SETTING_RST;
         table_src_q <= SETTING_RST;
         rw_busy_q   <= 1'b1;
         rw_idx_q    <= '0;
      end else begin
         if (wr_ctrl & wstrb_q[0]) begin
            loop_en_q <= wdata_q[CTRL_LOOP_BIT];
            mon_en_q  <= wdata_q[CTRL_MON_BIT];
         end
         if (wr_tgt) begin
            target_q <= tgt_clamped;
         end
         if (!loop_en_q) begin
            setting_q <= target_q;
         end else if (corr_tick) begin
            if (meas_new < target_q && setting_q != SETTING_MAX) begin
               setting_q <= setting_q + 12'h001;
            end else if (meas_new > target_q && setting_q != SETTING_MIN) begin
               setting_q <= setting_q - 12'h001;
            end
            // Equal measurement leaves setting alone
         end
         if (rw_busy_q) begin
            rw_idx_q <= rw_idx_q + 4'h1;
            if (rw_idx_q == 4'hF) begin
               rw_busy_q <= 1'b0;
            end
         end else if (setting_q != table_src_q) begin
            table_src_q <= setting_q;
            rw_busy_q   <= 1'b1;
         end
      end
   end

   // Offset test sweep and monitor value requests
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         test_run_q  <= 1'b0;
         test_code_q <= '0;
         mon_en_d1_q <= 1'b0;
         val_cnt_q   <= '0;
         val_due_q   <= 1'b0;
         mon_pend_q  <= 1'b0;
         mon_val_q   <= '0;
         mon_nch_q   <= '0;
         mon_term_q  <= CHAR_LF;
         line_cnt_q  <= '0;
      end else begin
         mon_en_d1_q <= mon_en_q;
         val_cnt_q   <= (val_cnt_q == 20'(VALUE_CYCLES - 1)) ? '0
                        : val_cnt_q + 20'h1;
         if (test_start) begin
            test_run_q  <= 1'b1;
            test_code_q <= 8'h00;
         end else if (test_run_q & g256) begin
            test_code_q <= test_code_q + 8'h01;
            if (test_code_q == 8'hFF) begin
               test_run_q <= 1'b0;
            end
         end
         // A start in the take cycle still queues its value
         if (fmt_take) begin
            mon_pend_q <= 1'b0;
         end
         if (mon_start) begin
            mon_pend_q <= 1'b1;
            mon_val_q  <= {4'h0, target_q};
            mon_nch_q  <= 3'd3;
            mon_term_q <= CHAR_LF;
            line_cnt_q <= '0;
         end else if (test_run_q & g256) begin
            mon_pend_q <= 1'b1;
            mon_val_q  <= {2'b00, s16_done};
            mon_nch_q  <= 3'd4;
            mon_term_q <= CHAR_LF;
         end else if (mon_en_q & ~test_run_q & g16 & val_due_q) begin
            val_due_q  <= 1'b0;
            mon_pend_q <= 1'b1;
            mon_val_q  <= {4'h0, s16_done[13:2]};
            mon_nch_q  <= 3'd3;
            line_cnt_q <= line_cnt_q + 4'h1;
            mon_term_q <= (line_cnt_q == 4'hF) ? CHAR_LF
                                              : CHAR_COMMA;
         end
         // Pacing set beats a same-cycle clear, so no slot is lost
         if (val_cnt_q == 20'(VALUE_CYCLES - 1)) begin
            val_due_q <= 1'b1;
         end
      end
   end

   // Character formatter and serial transmitter
   fmt_state_e  fmt_q;
   logic [15:0] sh_val_q;
   logic [2:0]  nch_q;
   logic [7:0]  term_q;
   logic [9:0]  frame_q;
   logic [3:0]  bits_q;
   logic [7:0]  baud_q;
   wire         tx_idle = (bits_q == 4'h0);
   wire  [3:0]  nib = (nch_q == 3'd4) ? sh_val_q[15:12] :
                      (nch_q == 3'd3) ? sh_val_q[11:8]  :
                      (nch_q == 3'd2) ? sh_val_q[7:4]   : sh_val_q[3:0];
   wire  [7:0]  hex_ch = (nib < 4'hA) ? 8'h30 + 8'(nib)
                                      : 8'h37 + 8'(nib);
   wire  [7:0]  next_ch = (nch_q == 3'd0) ? term_q : hex_ch;
   wire         baud_tick = (baud_q == 8'(BIT_CYC - 1));
   assign fmt_take = mon_pend_q & (fmt_q == FMT_IDLE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fmt_q    <= FMT_IDLE;
         sh_val_q <= '0;
         nch_q    <= '0;
         term_q   <= CHAR_LF;
         frame_q  <= '1;
         bits_q   <= '0;
         baud_q   <= '0;
         monitor_serial_port <= 1'b1;
      end else begin
         unique case (fmt_q)
            FMT_IDLE: begin
               if (fmt_take) begin
                  sh_val_q <= mon_val_q;
                  nch_q    <= mon_nch_q;
                  term_q   <= mon_term_q;
                  fmt_q    <= FMT_SEND;
               end
            end
            FMT_SEND: begin
               if (tx_idle) begin
                  frame_q <= {1'b1, next_ch, 1'b0};
                  bits_q  <= 4'(FRAME_BITS);
                  baud_q  <= '0;
                  if (nch_q == 3'd0) begin
                     fmt_q <= FMT_IDLE;
                  end else begin
                     nch_q <= nch_q - 3'd1;
                  end
               end
            end
         endcase
         if (!tx_idle) begin
            monitor_serial_port <= frame_q[0];
            baud_q <= baud_tick ? '0 : baud_q + 8'h01;
            if (baud_tick) begin
               frame_q <= {1'b1, frame_q[9:1]};
               bits_q  <= bits_q - 4'h1;
            end
         end else begin
            monitor_serial_port <= 1'b1;
         end
      end
   end
endmodule

/* File: pwm_dither_closed_loop_test.sv */
// Self-checking bench for the dithering PWM controller
`timescale 1ns/100ps
module pwm_dither_closed_loop_test import pwm_dither_pkg::*;;
   localparam int CORR = 300;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_rvalid, slow;
   logic        feedback_valid, feedback_ready;
   logic        pwm_output_pin, monitor_serial_port;
   logic [4:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, got;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_wstrb;
   logic [9:0]  level, feedback_analog_input;
   logic [34:0] exp_q[$];
   logic [34:0] e;
   logic [7:0]  ch_q[$];
   string       msg = "D1B\n554,";
   int          num_errors = 0, tests_run = 0, cyc = 0, seed, k;

   pwm_dither_closed_loop #(.CORR_CYCLES(CORR), .VALUE_CYCLES(20)) dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .feedback_analog_input,
      .feedback_valid, .feedback_ready, .pwm_output_pin,
      .monitor_serial_port);
   adc_feedback_model adc_u (.aclk, .aresetn, .level, .slow,
      .sample(feedback_analog_input), .valid(feedback_valid),
      .ready(feedback_ready));

   task automatic check(input string what, input logic [33:0] seen,
                        input logic [33:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         check("wait bound", 34'h0, 34'h1);
         conclude();
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      exp_q.push_back({1'b1, r, 32'h0});
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      @(negedge aclk);
      for (k = 0; !(s_axi_awready && s_axi_wready) && k < 99; k++)
         @(negedge aclk);
      guard(k, 99);
      @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      @(negedge aclk);
      for (k = 0; !s_axi_bvalid && k < 99; k++) @(negedge aclk);
      guard(k, 99);
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] r, input logic care);
      exp_q.push_back({care, r, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      @(negedge aclk);
      for (k = 0; !s_axi_arready && k < 99; k++) @(negedge aclk);
      guard(k, 99);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(negedge aclk);
      for (k = 0; !s_axi_rvalid && k < 99; k++) @(negedge aclk);
      guard(k, 99);
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      got = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   // Setting read twice exactly three correction intervals apart
   task automatic loop_case(input logic [11:0] t, input logic [9:0] s,
                            input int dlt);
      int t0;
      level <= s;
      wr(CTRL_OFS, 32'h0, RESP_OKAY);
      wr(TARGET_OFS, {20'h0, t}, RESP_OKAY);
      repeat (2 * CORR) @(posedge aclk);
      wr(CTRL_OFS, 32'h1, RESP_OKAY);
      t0 = cyc;
      rd(SETTING_OFS, 32'h0, RESP_OKAY, 1'b0);
      while (cyc < t0 + 3 * CORR) @(posedge aclk);
      rd(SETTING_OFS, got + dlt, RESP_OKAY, 1'b1);
      rd(MEAS_OFS, {20'h0, s, 2'b00}, RESP_OKAY, 1'b1);
   endtask

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc > 80000) guard(1, 1);
      if (s_axi_bvalid && s_axi_bready) begin
         e = exp_q.pop_front();
         check("write resp", {s_axi_bresp, 32'h0}, e[33:0]);
      end
      if (s_axi_rvalid && s_axi_rready) begin
         e = exp_q.pop_front();
         if (e[34]) begin
            check("read", {s_axi_rresp, s_axi_rdata}, e[33:0]);
         end
      end
   end
   initial begin : uart_rx
      logic [8:0] f;
      logic [7:0] c;
      forever begin
         @(negedge monitor_serial_port);
         repeat (BIT_CYC / 2) @(posedge aclk);
         for (int b = 0; b < 9; b++) begin
            repeat (BIT_CYC) @(posedge aclk);
            f[b] = monitor_serial_port;
         end
         if (ch_q.size() > 0) begin
            c = ch_q.pop_front();
            check("serial char", {25'h0, f}, {25'h1, c});
         end
      end
   end

   initial begin
      logic [11:0] t;
      seed = 32'h0C77;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, slow} = 3'h0;
      s_axi_awaddr = 5'h00;
      s_axi_araddr = 5'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      level = 10'h000;
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rd(5'(4 * i), 32'h0, RESP_OKAY, 1'b1);
      end
      rd(5'h14, 32'h0, RESP_SLVERR, 1'b1);
      wr(SETTING_OFS, 32'h1, RESP_SLVERR);
      for (int i = 0; i < 6; i++) begin
         t = (i == 0) ? 12'hFFF : 12'($random(seed));
         wr(TARGET_OFS, {20'h0, t}, RESP_OKAY);
         t = (t > SETTING_MAX) ? SETTING_MAX : t;
         rd(SETTING_OFS, {20'h0, t}, RESP_OKAY, 1'b1);
      end
      loop_case(12'h100, 10'h000, 3);
      loop_case(12'h800, 10'h3FF, -3);
      loop_case(12'hFF0, 10'h000, 0);
      loop_case(12'h000, 10'h3FF, 0);
      loop_case(12'h400, 10'h100, 0);
      // Slow feed plus a busy formatter stalls and refills the sample buffer
      level <= 10'h155;
      slow <= 1'b1;
      wr(CTRL_OFS, 32'h0, RESP_OKAY);
      wr(TARGET_OFS, 32'h0000_0D1B, RESP_OKAY);
      repeat (100) @(posedge aclk);
      foreach (msg[i]) ch_q.push_back(msg[i]);
      wr(CTRL_OFS, 32'h2, RESP_OKAY);
      for (k = 0; ch_q.size() > 0 && k < 30000; k++) @(posedge aclk);
      guard(k, 30000);
      wr(CTRL_OFS, 32'h0, RESP_OKAY);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(SETTING_OFS, 32'h0, RESP_OKAY, 1'b1);
      // Offset sweep: first code reports a raw 16-sample sum
      level <= 10'h3FF;
      slow <= 1'b0;
      repeat (100) @(posedge aclk);
      msg = "3FF0\n";
      foreach (msg[i]) ch_q.push_back(msg[i]);
      wr(CTRL_OFS, 32'h4, RESP_OKAY);
      for (k = 0; ch_q.size() > 0 && k < 30000; k++) @(posedge aclk);
      guard(k, 30000);
      rd(CTRL_OFS, 32'h4, RESP_OKAY, 1'b1);
      conclude();
   end
endmodule

/* File: pwm_dither_pkg.sv */
// Constants, register map and types for the dithering PWM controller
package pwm_dither_pkg;
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned CLK_PERIOD_NS = 40;
   // PWM period and step pacing: 256 steps per period
   localparam int unsigned PWM_PERIOD_NS = 16_000;
   localparam int unsigned PWM_CYC       = PWM_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned PWM_STEPS     = 256;
   localparam int unsigned SEQ_LEN       = 16;
   // Closed-loop correction interval
   localparam int unsigned CORR_NS       = 156_250_000;
   localparam int unsigned CORR_CYC      = CORR_NS / CLK_PERIOD_NS;
   // Monitor value pacing, 102.4 Hz
   localparam int unsigned VALUE_NS      = 9_765_625;
   localparam int unsigned VALUE_CYC     = VALUE_NS / CLK_PERIOD_NS;
   // Serial monitor, 10-bit frames
   localparam int unsigned BAUD          = 115_200;
   localparam int unsigned BIT_CYC       = CLK_HZ / BAUD;
   localparam int unsigned FRAME_BITS    = 10;
   // Setting limits
   localparam logic [11:0] SETTING_MAX   = 12'hFF0;
   localparam logic [11:0] SETTING_MIN   = 12'h000;
   localparam logic [11:0] SETTING_RST   = 12'h000;
   localparam logic [9:0]  ROUND_HALF    = 10'h020;
   localparam int unsigned MEAS_SHIFT    = 6;
   localparam int unsigned MON_SHIFT     = 2;
   localparam int unsigned VALS_PER_LINE = 16;
   // Register byte offsets
   localparam logic [4:0] CTRL_OFS    = 5'h00;
   localparam logic [4:0] TARGET_OFS  = 5'h04;
   localparam logic [4:0] SETTING_OFS = 5'h08;
   localparam logic [4:0] MEAS_OFS    = 5'h0C;
   localparam logic [4:0] STATUS_OFS  = 5'h10;
   localparam int unsigned CTRL_LOOP_BIT = 0;
   localparam int unsigned CTRL_MON_BIT  = 1;
   localparam int unsigned CTRL_TEST_BIT = 2;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [7:0] CHAR_COMMA  = 8'h2C;
   localparam logic [7:0] CHAR_LF     = 8'h0A;

   typedef enum logic [1:0] {
      FMT_IDLE = 2'b01,
      FMT_SEND = 2'b10
   } fmt_state_e;
endpackage
